// ### rtl/i2cs_pkg.sv
// Purpose: Shared constants and types for the stop-collision and rate counter block
// Assumes: APB register word per offset, 8-bit data in the low bits
// Notes: Offsets are byte addresses

package i2cs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_RELOAD = 8'h00;
    localparam logic [7:0] ADDR_BUFFER = 8'h04;
    localparam logic [7:0] ADDR_CTL1 = 8'h08;
    localparam logic [7:0] ADDR_CTL2 = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // ************************************************************
    // Field positions and values
    // ************************************************************
    localparam int CTL1_WCOL_BIT = 7;
    localparam int CTL1_EN_BIT = 5;
    localparam int CTL2_STOP_BIT = 2;
    localparam int STAT_STOP_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int IRQ_PORT_BIT = 0;
    localparam int IRQ_COLL_BIT = 1;
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam logic [3:0] MODE_SPI_MASTER = 4'hA;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_IRQ = 2'h0;
    // Instruction cycle is four module clocks
    localparam logic [1:0] PRE_LAST = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_STOP_LOW = 3'h1,
        ST_STOP_REL = 3'h3,
        ST_STOP_CNT = 3'h2,
        ST_STOP_CHK = 3'h6,
        ST_STOP_DONE = 3'h7,
        ST_XFER = 3'h5
    } state_e;

    typedef struct packed {
        logic sda;
        logic scl;
    } pins_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] pre;
        logic exp;
        logic [9:0] since;
    } counter_s;

    typedef struct packed {
        state_e st;
        logic [7:0] reload;
        logic [7:0] buffer;
        logic [7:0] ctl1;
        logic stop_req;
        logic stop_det;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic sda_oe;
        logic scl_oe;
        logic sck;
        logic [4:0] half;
        logic cnt_load;
        logic cnt_run;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } main_s;

endpackage : i2cs_pkg

// ### rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous to pclk
// Notes: First stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // Bus lines idle high, so reset to released
    logic [1:0][W-1:0] q;
    logic [1:0][W-1:0] d;

    always_comb begin
        d[0] = async_in;
        d[1] = q[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q[1];

endmodule : pin_sync

`default_nettype wire

// ### rtl/rate_counter.sv
// Purpose: Reload down-counter timing the serial clock
// Assumes: One step per instruction cycle of four pclk
// Notes: Reloads itself at each rollover while running

`timescale 1ns/1ps
`default_nettype none

module rate_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic run,
    input wire logic [7:0] reload,
    output logic expire
);

    i2cs_pkg::counter_s q;
    i2cs_pkg::counter_s d;

    always_comb begin
        d = q;
        d.exp = 1'b0;
        if (load) begin
            d.cnt = reload;
            d.pre = 2'h0;
        end else if (run) begin
            d.pre = q.pre + 2'h1;
            if (q.pre == i2cs_pkg::PRE_LAST) begin
                if (q.cnt == 8'h00) begin
                    d.exp = 1'b1;
                    d.cnt = reload;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
        end
        // Observation only: cycles since load or last rollover
        if (load || d.exp) begin
            d.since = 10'h000;
        end else begin
            d.since = q.since + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expire = q.exp;

    // ************************************************************
    // Checks
    // ************************************************************
    rollover_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.exp && $past(run) && $stable(reload))
        |-> $past(q.since) == {reload, i2cs_pkg::PRE_LAST})
        else $error("rate counter rollover length wrong");

endmodule : rate_counter

`default_nettype wire

// ### rtl/i2c_master_stop_collision_brg.sv
// Purpose: Stop generation with collision detection and shared rate counter
// Assumes: Open-drain pins with external pull-ups, APB slave, pclk 10 MHz
// Notes: Data shifting and start conditions are not part of this block

`timescale 1ns/1ps
`default_nettype none

module i2c_master_stop_collision_brg #(
    parameter logic [4:0] HALF_LAST = 5'h0F
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic irq
);

    i2cs_pkg::main_s q;
    i2cs_pkg::main_s d;
    i2cs_pkg::pins_s pins;
    logic cnt_exp;
    logic setup;
    logic access;
    logic enabled;
    logic mode_i2c;
    logic mode_spi;
    logic ev_port;
    logic ev_coll;
    logic [1:0] rd_clr;

    // ************************************************************
    // Pin synchroniser and rate counter
    // ************************************************************
    pin_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({sda_in, scl_in}),
        .sync_out(pins)
    );

    rate_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .load(q.cnt_load),
        .run(q.cnt_run),
        .reload(q.reload),
        .expire(cnt_exp)
    );

    assign enabled = q.ctl1[i2cs_pkg::CTL1_EN_BIT];
    assign mode_i2c = q.ctl1[3:0] == i2cs_pkg::MODE_I2C_MASTER;
    assign mode_spi = q.ctl1[3:0] == i2cs_pkg::MODE_SPI_MASTER;
    assign setup = psel && penable && !q.pready;
    assign access = psel && penable && q.pready;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;
        d.cnt_load = 1'b0;
        ev_port = 1'b0;
        ev_coll = 1'b0;
        rd_clr = 2'b00;

        // APB: one wait state, read data latched in the setup-to-access cycle
        d.pready = setup;
        d.pslverr = 1'b0;
        if (setup && !pwrite) begin
            d.prdata = 32'h0000_0000;
            if (paddr == i2cs_pkg::ADDR_RELOAD) begin
                d.prdata[7:0] = q.reload;
            end else if (paddr == i2cs_pkg::ADDR_BUFFER) begin
                d.prdata[7:0] = q.buffer;
            end else if (paddr == i2cs_pkg::ADDR_CTL1) begin
                d.prdata[7:0] = q.ctl1;
            end else if (paddr == i2cs_pkg::ADDR_CTL2) begin
                d.prdata[i2cs_pkg::CTL2_STOP_BIT] = q.stop_req;
            end else if (paddr == i2cs_pkg::ADDR_STATUS) begin
                d.prdata[i2cs_pkg::STAT_STOP_BIT] = q.stop_det;
                d.prdata[i2cs_pkg::STAT_BUSY_BIT] = q.st != i2cs_pkg::ST_IDLE;
            end else if (paddr == i2cs_pkg::ADDR_IRQ_STAT) begin
                d.prdata[1:0] = q.irq_stat;
            end else if (paddr == i2cs_pkg::ADDR_IRQ_MASK) begin
                d.prdata[1:0] = q.irq_mask;
            end else begin
                d.pslverr = 1'b1;
            end
        end else if (setup) begin
            if (paddr != i2cs_pkg::ADDR_RELOAD && paddr != i2cs_pkg::ADDR_BUFFER &&
                paddr != i2cs_pkg::ADDR_CTL1 && paddr != i2cs_pkg::ADDR_CTL2 &&
                paddr != i2cs_pkg::ADDR_STATUS && paddr != i2cs_pkg::ADDR_IRQ_STAT &&
                paddr != i2cs_pkg::ADDR_IRQ_MASK) begin
                d.pslverr = 1'b1;
            end
        end

        // Sequencer
        case (q.st)
            i2cs_pkg::ST_IDLE: begin
                if (q.stop_req && mode_i2c) begin
                    d.sda_oe = 1'b1;
                    d.st = i2cs_pkg::ST_STOP_LOW;
                end
            end
            i2cs_pkg::ST_STOP_LOW: begin
                if (!pins.sda) begin
                    d.scl_oe = 1'b0;
                    d.sck = 1'b1;
                    d.st = i2cs_pkg::ST_STOP_REL;
                end
            end
            i2cs_pkg::ST_STOP_REL: begin
                // Waits here while another device stretches the clock
                if (pins.scl) begin
                    d.cnt_load = 1'b1;
                    d.cnt_run = 1'b1;
                    d.st = i2cs_pkg::ST_STOP_CNT;
                end
            end
            i2cs_pkg::ST_STOP_CNT: begin
                if (!pins.scl) begin
                    ev_coll = 1'b1;
                end else if (cnt_exp) begin
                    d.sda_oe = 1'b0;
                    d.st = i2cs_pkg::ST_STOP_CHK;
                end
            end
            i2cs_pkg::ST_STOP_CHK: begin
                if (pins.sda && pins.scl) begin
                    d.stop_det = 1'b1;
                end
                if (!pins.scl && !pins.sda) begin
                    ev_coll = 1'b1;
                end else if (cnt_exp) begin
                    if (!pins.sda) begin
                        ev_coll = 1'b1;
                    end else begin
                        d.st = i2cs_pkg::ST_STOP_DONE;
                    end
                end
            end
            i2cs_pkg::ST_STOP_DONE: begin
                if (cnt_exp) begin
                    d.stop_req = 1'b0;
                    ev_port = 1'b1;
                    d.cnt_run = 1'b0;
                    d.st = i2cs_pkg::ST_IDLE;
                end
            end
            i2cs_pkg::ST_XFER: begin
                if (cnt_exp) begin
                    d.sck = !q.sck;
                    d.scl_oe = mode_spi || q.sck;
                    d.half = q.half + 5'h01;
                    if (q.half == HALF_LAST) begin
                        // Clock pin keeps its last level
                        d.cnt_run = 1'b0;
                        ev_port = 1'b1;
                        d.st = i2cs_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                d.st = i2cs_pkg::ST_IDLE;
            end
        endcase

        if (ev_coll) begin
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
            d.sck = 1'b1;
            d.stop_req = 1'b0;
            d.cnt_run = 1'b0;
            d.st = i2cs_pkg::ST_IDLE;
        end

        // Register writes take effect at the access edge
        if (access && pwrite) begin
            if (paddr == i2cs_pkg::ADDR_RELOAD) begin
                d.reload = pwdata[7:0];
            end else if (paddr == i2cs_pkg::ADDR_BUFFER) begin
                if (q.st != i2cs_pkg::ST_IDLE || q.stop_req) begin
                    d.ctl1[i2cs_pkg::CTL1_WCOL_BIT] = 1'b1;
                end else begin
                    d.buffer = pwdata[7:0];
                    if (enabled && (mode_i2c || mode_spi)) begin
                        d.cnt_load = 1'b1;
                        d.cnt_run = 1'b1;
                        d.half = 5'h00;
                        d.st = i2cs_pkg::ST_XFER;
                    end
                end
            end else if (paddr == i2cs_pkg::ADDR_CTL1) begin
                // Write collision flag is clear-only from software
                d.ctl1[6:0] = pwdata[6:0];
                d.ctl1[i2cs_pkg::CTL1_WCOL_BIT] = q.ctl1[i2cs_pkg::CTL1_WCOL_BIT] &&
                    pwdata[i2cs_pkg::CTL1_WCOL_BIT];
            end else if (paddr == i2cs_pkg::ADDR_CTL2) begin
                if (pwdata[i2cs_pkg::CTL2_STOP_BIT] && enabled && !ev_coll) begin
                    d.stop_req = 1'b1;
                end
            end else if (paddr == i2cs_pkg::ADDR_IRQ_MASK) begin
                d.irq_mask = pwdata[1:0];
            end
        end
        // Clear only what the read reported; a later event stays pending
        if (access && !pwrite && paddr == i2cs_pkg::ADDR_IRQ_STAT) begin
            rd_clr = q.prdata[1:0];
        end

        // Disabling the port aborts everything and clears the stop bit
        if (!d.ctl1[i2cs_pkg::CTL1_EN_BIT]) begin
            d.st = i2cs_pkg::ST_IDLE;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
            d.sck = 1'b1;
            d.stop_req = 1'b0;
            d.stop_det = 1'b0;
            d.cnt_run = 1'b0;
        end

        // Sticky events: a set in the clearing read cycle survives
        d.irq_stat = (q.irq_stat & ~rd_clr) | {ev_coll, ev_port};
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= i2cs_pkg::ST_IDLE;
            q.reload <= i2cs_pkg::RESET_BYTE;
            q.buffer <= i2cs_pkg::RESET_BYTE;
            q.ctl1 <= i2cs_pkg::RESET_BYTE;
            q.irq_stat <= i2cs_pkg::RESET_IRQ;
            q.irq_mask <= i2cs_pkg::RESET_IRQ;
            q.sck <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_oe;
    assign scl_out = q.sck;
    assign scl_oe = q.scl_oe;
    assign irq = q.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_wait_a: assert property (setup |=> pready)
        else $error("pready not raised after setup");
    stop_release_a: assert property (
        (q.st == i2cs_pkg::ST_STOP_LOW && !pins.sda && enabled) |=> !scl_oe && sda_oe)
        else $error("clock not released after data low");
    stop_load_a: assert property (
        (q.st == i2cs_pkg::ST_STOP_REL && pins.scl && enabled && !access) |=> q.cnt_load)
        else $error("counter not loaded on clock high");
    data_low_coll_a: assert property (
        (q.st == i2cs_pkg::ST_STOP_CHK && cnt_exp && !pins.sda && enabled)
        |=> q.irq_stat[i2cs_pkg::IRQ_COLL_BIT] && q.st == i2cs_pkg::ST_IDLE && !sda_oe)
        else $error("data low after count not flagged");
    clock_low_coll_a: assert property (
        (q.st == i2cs_pkg::ST_STOP_CNT && !pins.scl && enabled)
        |=> q.irq_stat[i2cs_pkg::IRQ_COLL_BIT] && !q.stop_req && !scl_oe)
        else $error("clock low during stop not flagged");
    buffer_start_a: assert property (
        (access && pwrite && paddr == i2cs_pkg::ADDR_BUFFER && q.st == i2cs_pkg::ST_IDLE &&
         !q.stop_req && enabled && (mode_i2c || mode_spi))
        |=> q.cnt_load && q.cnt_run && q.st == i2cs_pkg::ST_XFER)
        else $error("buffer write did not start counter");
    clock_hold_a: assert property (
        (q.st == i2cs_pkg::ST_IDLE && $past(q.st) == i2cs_pkg::ST_IDLE && $past(enabled))
        |-> $stable(scl_out) && !q.cnt_run)
        else $error("clock moved while idle");
    stop_seen_a: assert property (
        (q.st == i2cs_pkg::ST_STOP_CHK && pins.sda && pins.scl && enabled) |=> q.stop_det)
        else $error("stop not detected");
    stop_done_a: assert property (
        (q.st == i2cs_pkg::ST_STOP_DONE && cnt_exp && enabled)
        |=> !q.stop_req && q.irq_stat[i2cs_pkg::IRQ_PORT_BIT] ##1 !q.cnt_run)
        else $error("stop completion missing");
    irq_level_a: assert property (irq == |(q.irq_stat & q.irq_mask))
        else $error("interrupt level mismatch");

endmodule : i2c_master_stop_collision_brg

`default_nettype wire

// ### verification/bus_peer.sv
// Purpose: Other parties on the shared two-wire bus
// Assumes: Pull-ups on both lines, open-drain pull enables from the block
// Notes: The bench commands when another party holds a line low

`timescale 1ns/1ps
`default_nettype none

module bus_peer (
    input wire logic sda_oe,
    input wire logic scl_oe,
    input wire logic pull_sda,
    input wire logic pull_scl,
    output logic sda,
    output logic scl
);
    // ************************************************************
    // Wired-AND lines
    // ************************************************************
    // Released lines read the pull-up level, never the last value
    assign sda = !(sda_oe || pull_sda);
    // A held clock line models a slow party stretching the clock
    assign scl = !(scl_oe || pull_scl);
endmodule : bus_peer

`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for stop collision and rate counter
// Assumes: APB master tasks, bus_peer on the far side
// Notes: Half period count is reduced to keep the run short

`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [7:0] RLD = 8'h05;
    localparam int PER = 4 * (int'(RLD) + 1);
    logic pclk, presetn, psel, penable, pwrite, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sda_oe, scl_oe, scl_out, irq, sda, scl;
    logic pull_sda, pull_scl;
    logic [4:0] mon;
    int n_fail, n_checks, n;

    assign mon = {scl, irq, scl_out, scl_oe, sda_oe};

    i2c_master_stop_collision_brg #(.HALF_LAST(5'h03)) i2c_master_stop_collision_brg_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sda_in(sda), .scl_in(scl),
        .sda_out(), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq)
    );

    bus_peer bus_peer_i (
        .sda_oe(sda_oe), .scl_oe(scl_oe), .pull_sda(pull_sda), .pull_scl(pull_scl),
        .sda(sda), .scl(scl)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    // Request held until pready is sampled high, then released
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            chk("pready", 32'h1, 32'h0);
            summarize();
        end
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    // Bounded wait for a watched line, counting cycles in n
    task automatic wt(input int s, input logic v);
        #1;
        n = 0;
        while (mon[s] !== v) begin
            @(posedge pclk);
            #1;
            n++;
            if (n > 2000) begin
                chk("wait", 32'h1, 32'h0);
                summarize();
            end
        end
    endtask : wt

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pull_sda = 1'b0;
        pull_scl = 1'b0;
        n_fail = 0;
        n_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rdc("reset word", 8'(4 * a), 32'h0);
        end
        apb(8'h1C, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(8'h1C, 1'b1, 32'h1);
        chk("unmapped write error", 32'h1, {31'h0, er});
        apb(i2cs_pkg::ADDR_RELOAD, 1'b1, {24'h0, RLD});
        rdc("reload", i2cs_pkg::ADDR_RELOAD, {24'h0, RLD});
        apb(i2cs_pkg::ADDR_IRQ_MASK, 1'b1, 32'h1);
        // Same counter times the clock in both master modes
        for (int m = 0; m < 2; m++) begin
            apb(i2cs_pkg::ADDR_CTL1, 1'b1, {24'h0, 4'h2,
                (m == 0) ? i2cs_pkg::MODE_SPI_MASTER : i2cs_pkg::MODE_I2C_MASTER});
            apb(i2cs_pkg::ADDR_BUFFER, 1'b1, 32'h5A);
            wt(2, 1'b0);
            wt(2, 1'b1);
            chk("half period", PER, n);
            wt(3, 1'b1);
            rd = {31'h0, scl_out};
            repeat (40) @(posedge pclk);
            chk("held clock", rd, {31'h0, scl_out});
            rdc("irq status", i2cs_pkg::ADDR_IRQ_STAT, 32'h1);
            repeat (2) @(posedge pclk);
            #1;
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        // Good stop, clock held low by a slow party first
        @(posedge pclk);
        pull_scl <= 1'b1;
        apb(i2cs_pkg::ADDR_CTL2, 1'b1, 32'h4);
        wt(0, 1'b1);
        apb(i2cs_pkg::ADDR_BUFFER, 1'b1, 32'hC3);
        rdc("write collision", i2cs_pkg::ADDR_CTL1, 32'hA8);
        apb(i2cs_pkg::ADDR_CTL1, 1'b1, 32'h28);
        chk("data held low", 32'h1, {31'h0, sda_oe});
        @(posedge pclk);
        pull_scl <= 1'b0;
        wt(4, 1'b1);
        wt(0, 1'b0);
        chk("release delay", 32'h1, {31'h0, n >= PER && n <= PER + 6});
        wt(3, 1'b1);
        rdc("stop detected", i2cs_pkg::ADDR_STATUS, 32'h10);
        rdc("stop request", i2cs_pkg::ADDR_CTL2, 32'h0);
        rdc("irq status", i2cs_pkg::ADDR_IRQ_STAT, 32'h1);
        // Another master holds data low through the stop
        apb(i2cs_pkg::ADDR_IRQ_MASK, 1'b1, 32'h3);
        @(posedge pclk);
        pull_sda <= 1'b1;
        apb(i2cs_pkg::ADDR_CTL2, 1'b1, 32'h4);
        wt(3, 1'b1);
        rdc("stop aborted", i2cs_pkg::ADDR_CTL2, 32'h0);
        chk("lines released", 32'h0, {30'h0, sda_oe, scl_oe});
        apb(i2cs_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(i2cs_pkg::ADDR_IRQ_MASK, 1'b1, 32'h3);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, irq});
        rdc("collision flag", i2cs_pkg::ADDR_IRQ_STAT, 32'h2);
        @(posedge pclk);
        pull_sda <= 1'b0;
        // Clock pulled low while the counter runs
        apb(i2cs_pkg::ADDR_CTL2, 1'b1, 32'h4);
        wt(0, 1'b1);
        repeat (12) @(posedge pclk);
        pull_scl <= 1'b1;
        wt(3, 1'b1);
        rdc("collision flag", i2cs_pkg::ADDR_IRQ_STAT, 32'h2);
        chk("data released", 32'h0, {31'h0, sda_oe});
        @(posedge pclk);
        pull_scl <= 1'b0;
        summarize();
    end
endmodule : tb_top

`default_nettype wire
